/* File: rtl/pin_mux_pkg.sv */
`default_nettype none
package pin_mux_pkg;
    // register byte offsets on the 32-bit bus
    localparam logic [7:0] STRAP_CFG_OFS  = 8'h00;
    localparam logic [7:0] IRQ_MODE_OFS   = 8'h04;
    localparam logic [7:0] DECODE_CFG_OFS = 8'h08;
    localparam logic [7:0] CLOCK_CFG_OFS  = 8'h0c;
    localparam logic [7:0] PRT_MODE_OFS   = 8'h10;
    localparam logic [7:0] PIN_CTRL_OFS   = 8'h14;
    localparam logic [7:0] GPIO_OFS       = 8'h18;
    localparam logic [7:0] PIN_STATUS_OFS = 8'h1c;
    // field positions
    localparam int SC_SENSE_EN  = 7;
    localparam int SC_WIDE_DIS  = 6;
    localparam int SC_IRQ_GPIO  = 4;
    localparam int SC_PNP       = 2;
    localparam int SC_CFG_PORT  = 0;
    localparam int IM_SERIAL    = 2;
    localparam int DC_WIDE_STRP = 6;
    localparam int CC_FREQ      = 0;
    localparam int PC_SCI_IRQA  = 0;
    localparam int PC_FIR_OUT   = 1;
    localparam int PC_IR_SEL0   = 2;
    localparam int PC_COMB_IR   = 3;
    localparam int PC_ACPI      = 4;
    // pull values of the strap pins, used until the strap load
    localparam logic WIDE_STRAP_RST = 1'b1;
    localparam logic CFG_PORT_RST   = 1'b0;
    localparam logic PNP_STRAP_RST  = 1'b1;
    localparam logic IRQ_GPIO_RST   = 1'b0;
    localparam logic [2:0] PRT_MODE_RST = 3'h0;
    localparam logic [2:0] PRT_EXT_FDD  = 3'h3;
    localparam logic [2:0] PRT_EXT_2FDD = 3'h7;
    localparam logic [15:0] CFG_PORT_LOW  = 16'h0250;
    localparam logic [15:0] CFG_PORT_HIGH = 16'h03f0;

    typedef enum logic [2:0] {
        ST_HOLD = 3'h1,
        ST_LOAD = 3'h2,
        ST_RUN  = 3'h4
    } strap_state_e;

    typedef struct packed {
        logic wide_decode;
        logic config_port;
        logic plugplay_compat;
        logic irq_or_gpio;
    } strap_s;

    typedef struct packed {
        logic   printer_not_floppy_sense;
        logic   chip_select_n;
        logic   cts_b_n;
        logic   dsr_b_n;
        logic   dcd_b_n;
        logic   ri_b_n;
        logic   irq_a_i;
        logic   irq_b_i;
        logic   irq_g_i;
        logic   fast_ir_i;
        logic   sin_b;
        logic   busy_i;
        logic   ack_n_i;
        strap_s straps;
    } pins_in_s;

    typedef struct packed {
        logic       floppy_sense_pin_enable;
        logic       wide_decode_disable_n;
        logic       irq_or_gpio_select;
        logic       plugplay_compat_bit;
        logic       config_port_select;
        logic       serial_irq_mode_bit;
        logic       wide_decode_strap;
        logic       input_clock_freq_select;
        logic [2:0] printer_mode;
        logic       sci_on_irq_a;
        logic       fast_ir_output;
        logic       ir_module_select0;
        logic       com_b_infrared;
        logic       acpi_mode;
        logic [1:0] gpio_out;
        logic [1:0] gpio_oe;
    } cfg_s;
endpackage
`default_nettype wire

/* File: rtl/sync_vec.sv */
`default_nettype none
module sync_vec #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    // no reset: straps must be sampled while reset is held
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule
`default_nettype wire

/* File: rtl/strap_capture.sv */
`default_nettype none
module strap_capture (
    input  wire logic                mclk,
    input  wire logic                srst,
    input  wire pin_mux_pkg::strap_s pins_sync,
    output pin_mux_pkg::strap_s      straps,
    output logic                     load
);
    import pin_mux_pkg::*;
    strap_state_e state_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_HOLD;
        end else begin
            case (state_r)
                ST_HOLD: state_r <= ST_LOAD;
                ST_LOAD: state_r <= ST_RUN;
                ST_RUN:  state_r <= ST_RUN;
                default: state_r <= ST_HOLD;
            endcase
        end
    end

    // tracks the pins during reset, frozen from the release on
    always_ff @(posedge mclk) begin
        if (srst) begin
            straps <= pins_sync;
        end
    end

    assign load = (state_r == ST_LOAD);
endmodule
`default_nettype wire

/* File: rtl/superio_pin_function_mux.sv */
`default_nettype none
module superio_pin_function_mux (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire pin_mux_pkg::pins_in_s pins_i,
    input  wire logic [7:0]            irq_req,
    input  wire logic                  pm_event,
    input  wire logic                  serial_irq_data,
    input  wire logic                  uart_b_tx,
    input  wire logic                  ir_transmit_one,
    input  wire logic                  external_motor_on_n,
    input  wire logic                  external_drive_select_n,
    output logic                       irq_a_o,
    output logic                       irq_a_oe,
    output logic                       irq_b_o,
    output logic                       irq_b_oe,
    output logic      [3:0]            irq_cf_o,
    output logic                       irq_g_o,
    output logic                       irq_g_oe,
    output logic                       irq_h_o,
    output logic                       system_mgmt_interrupt_n,
    output logic                       fast_ir_o,
    output logic                       fast_ir_oe,
    output logic                       sout_b_o,
    output logic                       busy_o,
    output logic                       busy_oe,
    output logic                       ack_o,
    output logic                       ack_oe,
    output logic      [4:0]            host_addr_hi,
    output logic                       wide_decode_en,
    output logic                       chip_select_n,
    output logic      [15:0]           config_port_base,
    output logic                       pci_clk_sample,
    output logic                       fast_ir_receive,
    output logic                       ir_receive_one,
    output logic                       com_b_sin,
    output logic                       printer_route,
    output logic                       ext_floppy_mode,
    output logic                       printer_busy,
    output logic                       printer_ack_n
);
    import pin_mux_pkg::*;

    pins_in_s pins_s;
    strap_s   straps;
    logic     strap_load;
    cfg_s     cfg_r;
    logic     req;
    logic     wr_en;
    logic     sci_lvl;
    logic     ext_fdd;
    logic [1:0] gpio_in;
    logic [7:0] rd_nxt;

    function automatic logic is_ext_floppy(input logic [2:0] mode);
        is_ext_floppy = (mode == PRT_EXT_FDD) || (mode == PRT_EXT_2FDD);
    endfunction

    sync_vec #(
        .W($bits(pins_in_s))
    ) u_sync (
        .clk(mclk),
        .d  (pins_i),
        .q  (pins_s)
    );

    strap_capture u_strap (
        .mclk     (mclk),
        .srst     (srst),
        .pins_sync(pins_s.straps),
        .straps   (straps),
        .load     (strap_load)
    );

    // bus slave: one wait state, unmapped reads return zero
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge mclk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    assign gpio_in = {pins_s.irq_a_i, pins_s.irq_b_i};

    always_comb begin
        rd_nxt = 8'h00;
        case (wb_adr_i)
            STRAP_CFG_OFS: begin
                rd_nxt[SC_SENSE_EN] = cfg_r.floppy_sense_pin_enable;
                rd_nxt[SC_WIDE_DIS] = cfg_r.wide_decode_disable_n;
                rd_nxt[SC_IRQ_GPIO] = cfg_r.irq_or_gpio_select;
                rd_nxt[SC_PNP]      = cfg_r.plugplay_compat_bit;
                rd_nxt[SC_CFG_PORT] = cfg_r.config_port_select;
            end
            IRQ_MODE_OFS:   rd_nxt[IM_SERIAL] = cfg_r.serial_irq_mode_bit;
            DECODE_CFG_OFS: rd_nxt[DC_WIDE_STRP] = cfg_r.wide_decode_strap;
            CLOCK_CFG_OFS:  rd_nxt[CC_FREQ] = cfg_r.input_clock_freq_select;
            PRT_MODE_OFS:   rd_nxt[2:0] = cfg_r.printer_mode;
            PIN_CTRL_OFS: begin
                rd_nxt[PC_SCI_IRQA] = cfg_r.sci_on_irq_a;
                rd_nxt[PC_FIR_OUT]  = cfg_r.fast_ir_output;
                rd_nxt[PC_IR_SEL0]  = cfg_r.ir_module_select0;
                rd_nxt[PC_COMB_IR]  = cfg_r.com_b_infrared;
                rd_nxt[PC_ACPI]     = cfg_r.acpi_mode;
            end
            GPIO_OFS:       rd_nxt[5:0] = {gpio_in, cfg_r.gpio_oe, cfg_r.gpio_out};
            PIN_STATUS_OFS: rd_nxt[4:0] = {pci_clk_sample, wide_decode_en, ext_floppy_mode,
                                           printer_route, pins_s.printer_not_floppy_sense};
            default:        rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wb_dat_o <= 32'h0;
        end else if (req) begin
            wb_dat_o <= {24'h0, rd_nxt};
        end
    end

    // configuration; a write in the load cycle loses to the straps
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_r <= '0;
            cfg_r.wide_decode_disable_n <= WIDE_STRAP_RST;
            cfg_r.wide_decode_strap     <= WIDE_STRAP_RST;
            cfg_r.config_port_select    <= CFG_PORT_RST;
            cfg_r.plugplay_compat_bit   <= PNP_STRAP_RST;
            cfg_r.irq_or_gpio_select    <= IRQ_GPIO_RST;
            cfg_r.printer_mode          <= PRT_MODE_RST;
        end else if (strap_load) begin
            cfg_r.wide_decode_strap     <= straps.wide_decode;
            cfg_r.wide_decode_disable_n <= straps.wide_decode;
            cfg_r.config_port_select    <= straps.config_port;
            cfg_r.plugplay_compat_bit   <= straps.plugplay_compat;
            cfg_r.irq_or_gpio_select    <= straps.irq_or_gpio;
        end else if (wr_en) begin
            case (wb_adr_i)
                STRAP_CFG_OFS: begin
                    cfg_r.floppy_sense_pin_enable <= wb_dat_i[SC_SENSE_EN];
                    cfg_r.wide_decode_disable_n   <= wb_dat_i[SC_WIDE_DIS];
                    cfg_r.irq_or_gpio_select      <= wb_dat_i[SC_IRQ_GPIO];
                    cfg_r.plugplay_compat_bit     <= wb_dat_i[SC_PNP];
                    cfg_r.config_port_select      <= wb_dat_i[SC_CFG_PORT];
                end
                IRQ_MODE_OFS:   cfg_r.serial_irq_mode_bit <= wb_dat_i[IM_SERIAL];
                DECODE_CFG_OFS: cfg_r.wide_decode_strap <= wb_dat_i[DC_WIDE_STRP];
                CLOCK_CFG_OFS:  cfg_r.input_clock_freq_select <= wb_dat_i[CC_FREQ];
                PRT_MODE_OFS:   cfg_r.printer_mode <= wb_dat_i[2:0];
                PIN_CTRL_OFS: begin
                    cfg_r.sci_on_irq_a      <= wb_dat_i[PC_SCI_IRQA];
                    cfg_r.fast_ir_output    <= wb_dat_i[PC_FIR_OUT];
                    cfg_r.ir_module_select0 <= wb_dat_i[PC_IR_SEL0];
                    cfg_r.com_b_infrared    <= wb_dat_i[PC_COMB_IR];
                    cfg_r.acpi_mode         <= wb_dat_i[PC_ACPI];
                end
                GPIO_OFS: begin
                    cfg_r.gpio_out <= wb_dat_i[1:0];
                    cfg_r.gpio_oe  <= wb_dat_i[3:2];
                end
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    // power events split by acpi mode
    assign sci_lvl = pm_event && cfg_r.acpi_mode;

    always_ff @(posedge mclk) begin
        if (srst) begin
            system_mgmt_interrupt_n <= 1'b1;
        end else begin
            system_mgmt_interrupt_n <= !(pm_event && !cfg_r.acpi_mode);
        end
    end

    // shared interrupt pins
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_a_o  <= 1'b0;
            irq_a_oe <= 1'b0;
            irq_b_o  <= 1'b0;
            irq_b_oe <= 1'b0;
        end else if (!cfg_r.irq_or_gpio_select) begin
            irq_a_oe <= 1'b1;
            irq_b_oe <= 1'b1;
            irq_b_o  <= irq_req[1];
            irq_a_o  <= cfg_r.sci_on_irq_a ? sci_lvl : irq_req[0];
        end else begin
            irq_a_o  <= cfg_r.gpio_out[1];
            irq_a_oe <= cfg_r.gpio_oe[1];
            irq_b_o  <= cfg_r.gpio_out[0];
            irq_b_oe <= cfg_r.gpio_oe[0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_cf_o       <= 4'h0;
            irq_g_o        <= 1'b0;
            irq_g_oe       <= 1'b0;
            irq_h_o        <= 1'b0;
            pci_clk_sample <= 1'b0;
        end else begin
            irq_cf_o <= irq_req[5:2];
            irq_g_o  <= irq_req[6];
            // pin G becomes the pci clock input
            irq_g_oe       <= !cfg_r.serial_irq_mode_bit;
            pci_clk_sample <= cfg_r.serial_irq_mode_bit && pins_s.irq_g_i;
            irq_h_o <= cfg_r.serial_irq_mode_bit ? serial_irq_data : irq_req[7];
        end
    end

    // address extension on modem inputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            wide_decode_en   <= 1'b0;
            host_addr_hi     <= 5'h00;
            chip_select_n    <= 1'b1;
            config_port_base <= CFG_PORT_LOW;
        end else begin
            wide_decode_en <= !cfg_r.wide_decode_disable_n;
            if (!cfg_r.wide_decode_disable_n) begin
                host_addr_hi[4:1] <= {pins_s.ri_b_n, pins_s.dcd_b_n,
                                      pins_s.dsr_b_n, pins_s.cts_b_n};
                host_addr_hi[0] <= pins_s.chip_select_n;
                chip_select_n   <= 1'b1;
            end else begin
                host_addr_hi  <= 5'h00;
                chip_select_n <= pins_s.chip_select_n;
            end
            config_port_base <= cfg_r.config_port_select ? CFG_PORT_HIGH : CFG_PORT_LOW;
        end
    end

    // infrared pin sharing
    always_ff @(posedge mclk) begin
        if (srst) begin
            fast_ir_o       <= 1'b0;
            fast_ir_oe      <= 1'b0;
            fast_ir_receive <= 1'b0;
            sout_b_o        <= 1'b1;
            ir_receive_one  <= 1'b0;
            com_b_sin       <= 1'b1;
        end else begin
            fast_ir_oe      <= cfg_r.fast_ir_output;
            fast_ir_o       <= cfg_r.ir_module_select0;
            fast_ir_receive <= !cfg_r.fast_ir_output && pins_s.fast_ir_i;
            // port B as infrared port; the idle uart sees a mark
            if (cfg_r.com_b_infrared) begin
                sout_b_o       <= ir_transmit_one;
                ir_receive_one <= pins_s.sin_b;
                com_b_sin      <= 1'b1;
            end else begin
                sout_b_o       <= uart_b_tx;
                ir_receive_one <= 1'b0;
                com_b_sin      <= pins_s.sin_b;
            end
        end
    end

    // sense pin overrides the mode bits
    assign ext_fdd = cfg_r.floppy_sense_pin_enable ? !pins_s.printer_not_floppy_sense
                                                   : is_ext_floppy(cfg_r.printer_mode);

    // parallel pins; open-drain outputs only ever pull low
    always_ff @(posedge mclk) begin
        if (srst) begin
            printer_route   <= 1'b1;
            ext_floppy_mode <= 1'b0;
            busy_o          <= 1'b0;
            busy_oe         <= 1'b0;
            ack_o           <= 1'b0;
            ack_oe          <= 1'b0;
            printer_busy    <= 1'b0;
            printer_ack_n   <= 1'b1;
        end else begin
            printer_route   <= !ext_fdd;
            ext_floppy_mode <= ext_fdd;
            busy_o          <= 1'b0;
            ack_o           <= 1'b0;
            busy_oe      <= ext_fdd && !external_motor_on_n;
            printer_busy <= !ext_fdd && pins_s.busy_i;
            ack_oe        <= ext_fdd && !external_drive_select_n;
            printer_ack_n <= ext_fdd || pins_s.ack_n_i;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence wb_ans_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    wb_one_wait_a: assert property (wb_req_s |=> wb_ans_s)
        else $error("bus answer not a one-cycle ack after one wait");
    strap_load_a: assert property (strap_load |=> cfg_r.wide_decode_strap == $past(straps.wide_decode) &&
        cfg_r.config_port_select == $past(straps.config_port))
        else $error("decode or port strap not loaded");
    strap_pnp_a: assert property (strap_load |=>
        cfg_r.plugplay_compat_bit == $past(straps.plugplay_compat) &&
        cfg_r.irq_or_gpio_select == $past(straps.irq_or_gpio))
        else $error("compat or select strap not loaded");
    irq_mode_a: assert property (!cfg_r.irq_or_gpio_select |=> irq_b_oe && irq_b_o == $past(irq_req[1]))
        else $error("irq B not driven in interrupt mode");
    sci_route_a: assert property (!cfg_r.irq_or_gpio_select && cfg_r.sci_on_irq_a |=> irq_a_o == $past(sci_lvl))
        else $error("control interrupt not on irq A");
    serial_irq_a: assert property (cfg_r.serial_irq_mode_bit |=> irq_h_o == $past(serial_irq_data) && !irq_g_oe)
        else $error("serial irq pins wrong");
    wide_decode_a: assert property (!cfg_r.wide_decode_disable_n |=>
        host_addr_hi == $past({pins_s.ri_b_n, pins_s.dcd_b_n, pins_s.dsr_b_n, pins_s.cts_b_n, pins_s.chip_select_n}))
        else $error("address extension wrong");
    cfg_port_a: assert property (cfg_r.config_port_select [*2] |-> config_port_base == CFG_PORT_HIGH)
        else $error("config port not at high base");
    mgmt_irq_a: assert property (pm_event && !cfg_r.acpi_mode |=> !system_mgmt_interrupt_n)
        else $error("management interrupt not low");
    sense_route_a: assert property (cfg_r.floppy_sense_pin_enable && !pins_s.printer_not_floppy_sense
        |=> ext_floppy_mode && !printer_route)
        else $error("sense pin low did not route floppy");
    motor_on_a: assert property (ext_floppy_mode && $past(!external_motor_on_n) |-> busy_oe && !busy_o)
        else $error("motor on not pulled low");
    ir_tx_a: assert property (cfg_r.com_b_infrared |=> sout_b_o == $past(ir_transmit_one))
        else $error("ir transmit not on serial output");
endmodule
`default_nettype wire

/* File: sim/far_side_model.sv */
`default_nettype none
module far_side_model (
    input  wire logic                  mclk,
    input  wire pin_mux_pkg::pins_in_s want,
    input  wire logic                  busy_oe,
    input  wire logic                  ack_oe,
    output pin_mux_pkg::pins_in_s      pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;
    logic pci_clk_r = 1'b0;
    always @(posedge mclk) pci_clk_r <= ~pci_clk_r;
    always_comb begin
        pins = want;
        pins.irq_g_i = pci_clk_r;
        // pulled up unless the device sinks it
        pins.busy_i = want.busy_i & ~busy_oe;
        pins.ack_n_i = want.ack_n_i & ~ack_oe;
    end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic pm_event = 1'b0, serial_irq_data = 1'b0, uart_b_tx = 1'b1, ir_transmit_one = 1'b0;
    logic external_motor_on_n = 1'b0, external_drive_select_n = 1'b0, e;
    logic [7:0] wb_adr_i = 8'h00, irq_req = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [15:0] config_port_base;
    logic [4:0] host_addr_hi;
    logic wb_ack_o, irq_a_o, irq_a_oe, irq_b_oe, irq_g_oe, irq_h_o, system_mgmt_interrupt_n;
    logic busy_oe, ack_oe, wide_decode_en, printer_route, ext_floppy_mode;
    logic irq_b_o, irq_g_o, fast_ir_o, fast_ir_oe, sout_b_o, busy_o, ack_o, chip_select_n, pci_clk_sample, p;
    logic fast_ir_receive, ir_receive_one, com_b_sin, printer_busy, printer_ack_n;
    logic [3:0] irq_cf_o;
    pins_in_s want, pins_i;
    int failures = 0, n_compared = 0;

    far_side_model far_u (.mclk, .want, .busy_oe, .ack_oe, .pins(pins_i));
    superio_pin_function_mux dut_u (
        .mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
        .wb_ack_o, .pins_i, .irq_req, .pm_event, .serial_irq_data, .uart_b_tx, .ir_transmit_one,
        .external_motor_on_n, .external_drive_select_n, .irq_a_o, .irq_a_oe, .irq_b_o, .irq_b_oe,
        .irq_cf_o, .irq_g_o, .irq_g_oe, .irq_h_o, .system_mgmt_interrupt_n, .fast_ir_o,
        .fast_ir_oe, .sout_b_o, .busy_o, .busy_oe, .ack_o, .ack_oe, .host_addr_hi,
        .wide_decode_en, .chip_select_n, .config_port_base, .pci_clk_sample, .fast_ir_receive,
        .ir_receive_one, .com_b_sin, .printer_route, .ext_floppy_mode, .printer_busy,
        .printer_ack_n
    );

    always #4 mclk = ~mclk;

    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        n_compared++;
        if (s !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask

    // one classic cycle; at least one idle cycle always precedes it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            report_and_stop;
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    initial begin
        want = '0;
        want.straps = 4'h5;
        want.chip_select_n = 1'b1;
        want.dsr_b_n = 1'b1;
        want.ri_b_n = 1'b1;
        want.ack_n_i = 1'b1;
        want.printer_not_floppy_sense = 1'b1;
        wt(6);
        srst <= 1'b0;
        wt(3);
        acc(0, STRAP_CFG_OFS, 0);
        chk("strap_config_reg", 32'h11, rd);
        acc(0, DECODE_CFG_OFS, 0);
        chk("decode_config_reg", 32'h0, rd);
        chk("config_port_base", CFG_PORT_HIGH, config_port_base);
        chk("wide_decode_en", 1, wide_decode_en);
        chk("host_addr_hi", 5'h15, host_addr_hi);
        acc(0, 8'h40, 0);
        chk("unmapped", 0, rd);
        irq_req <= 8'h01;
        acc(1, STRAP_CFG_OFS, 8'h00);
        wt(3);
        chk("irq_a_o", 1, irq_a_o);
        chk("irq_b_oe", 1, irq_b_oe);
        acc(1, STRAP_CFG_OFS, 8'h10);
        acc(1, GPIO_OFS, 8'h00);
        wt(3);
        chk("irq_a_oe", 0, irq_a_oe);
        acc(1, GPIO_OFS, 8'h0d);
        serial_irq_data <= 1'b1;
        acc(1, IRQ_MODE_OFS, 8'h04);
        pm_event <= 1'b1;
        wt(3);
        chk("gpio_a", 2, {irq_a_oe, irq_a_o});
        chk("gpio_b", 1, irq_b_o);
        chk("irq_h_o", 1, irq_h_o);
        chk("irq_g_oe", 0, irq_g_oe);
        chk("smi_legacy", 0, system_mgmt_interrupt_n);
        acc(1, PIN_CTRL_OFS, 8'h10);
        wt(2);
        chk("smi_acpi", 1, system_mgmt_interrupt_n);
        want.busy_i <= 1'b1;
        want.ack_n_i <= 1'b0;
        for (int m = 0; m < 8; m++) begin
            acc(1, PRT_MODE_OFS, m[7:0]);
            wt(2);
            e = (m == 3 || m == 7);
            chk("ext_floppy_mode", e, ext_floppy_mode);
            chk("busy_oe", e, busy_oe);
            chk("ack_oe", e, ack_oe);
        end
        chk("busy_o", 0, busy_o);
        chk("ack_o", 0, ack_o);
        chk("busy_gated", 0, printer_busy);
        chk("ack_gated", 1, printer_ack_n);
        external_motor_on_n <= 1'b1;
        external_drive_select_n <= 1'b1;
        wt(2);
        chk("busy_oe_idle", 0, busy_oe);
        chk("ack_oe_idle", 0, ack_oe);
        acc(1, PRT_MODE_OFS, 0);
        wt(2);
        chk("printer_busy", 1, printer_busy);
        chk("printer_ack_n", 0, printer_ack_n);
        acc(1, STRAP_CFG_OFS, 8'h80);
        want.printer_not_floppy_sense <= 1'b0;
        wt(4);
        chk("route_floppy", 0, printer_route);
        want.printer_not_floppy_sense <= 1'b1;
        wt(4);
        chk("route_printer", 1, printer_route);
        irq_req <= 8'h00;
        acc(1, PIN_CTRL_OFS, 8'h11);
        wt(2);
        chk("sci_on_irq_a", 1, irq_a_o);
        pm_event <= 1'b0;
        wt(2);
        chk("sci_idle", 0, irq_a_o);
        uart_b_tx <= 1'b0;
        ir_transmit_one <= 1'b1;
        want.sin_b <= 1'b1;
        want.fast_ir_i <= 1'b1;
        acc(1, PIN_CTRL_OFS, 8'h0e);
        wt(3);
        chk("fast_ir_oe", 1, fast_ir_oe);
        chk("fast_ir_o", 1, fast_ir_o);
        chk("fast_ir_receive", 0, fast_ir_receive);
        chk("sout_b_ir", 1, sout_b_o);
        chk("ir_receive_one", 1, ir_receive_one);
        chk("com_b_sin_ir", 1, com_b_sin);
        acc(1, PIN_CTRL_OFS, 8'h00);
        wt(2);
        chk("fast_ir_oe_off", 0, fast_ir_oe);
        chk("fast_ir_in", 1, fast_ir_receive);
        chk("sout_b_uart", 0, sout_b_o);
        chk("ir_receive_off", 0, ir_receive_one);
        chk("com_b_sin_uart", 1, com_b_sin);
        want.chip_select_n <= 1'b0;
        acc(1, STRAP_CFG_OFS, 8'h40);
        wt(3);
        chk("cs_decode_off", 0, chip_select_n);
        chk("addr_hi_off", 0, host_addr_hi);
        acc(1, STRAP_CFG_OFS, 8'h00);
        wt(2);
        chk("cs_decode_on", 1, chip_select_n);
        chk("addr_hi_on", 5'h14, host_addr_hi);
        p = pci_clk_sample;
        wt(1);
        chk("pci_clk_sample", !p, pci_clk_sample);
        serial_irq_data <= 1'b0;
        irq_req <= 8'hfc;
        acc(1, IRQ_MODE_OFS, 8'h00);
        wt(2);
        chk("irq_g_oe_on", 1, irq_g_oe);
        chk("pci_clk_off", 0, pci_clk_sample);
        chk("irq_g_o", 1, irq_g_o);
        chk("irq_h_plain", 1, irq_h_o);
        chk("irq_cf_o", 4'hf, irq_cf_o);
        acc(1, CLOCK_CFG_OFS, 8'h01);
        acc(0, CLOCK_CFG_OFS, 8'h00);
        chk("clock_config_reg", 1, rd);
        want.irq_a_i <= 1'b1;
        wt(2);
        acc(0, GPIO_OFS, 8'h00);
        chk("gpio_reg", 8'h2d, rd);
        report_and_stop;
    end
endmodule
`default_nettype wire
